//--- rtl/slt_defs.svh
// Register map, field positions, reset values and code constants of the link transmit block
`ifndef SLT_DEFS_SVH
`define SLT_DEFS_SVH

`define SLT_ADDR_W          8
`define SLT_ADDR_LINK_CTRL  8'h01
`define SLT_ADDR_TEST_FRAME 8'h03
`define SLT_ADDR_ALIGN_DLY  8'h04
`define SLT_ADDR_SCRAMBLE   8'h06
`define SLT_ADDR_MF_LEN     8'h07
`define SLT_ADDR_LANE_SRC   8'h16
`define SLT_ADDR_RATIO      8'h36

`define SLT_TP_MSB       7
`define SLT_TP_LSB       5
`define SLT_RPAT_FLIP    4
`define SLT_MASK_CLEAR   3
`define SLT_FA_HI        2
`define SLT_FA_LO        1
`define SLT_RAMP_EN      0
`define SLT_OVERRIDE_BIT 7
`define SLT_SCR_EN_BIT   7
`define SLT_RATIO80_BIT  7
`define SLT_TEST_RESET   8'h04
`define SLT_LANE_RESET   8'h00

`define SLT_TP_D215  3'h1
`define SLT_TP_K285  3'h2
`define SLT_TP_ILA   3'h3
`define SLT_TP_RPAT  3'h4

`define SLT_K_DEFAULT   6'h05
`define SLT_ILA_MF_LAST 2'h3
`define SLT_RPAT_LAST   4'hb
`define SLT_SCR_SEED    15'h7fff

`define SLT_CH_D215 8'hb5
`define SLT_CH_K285 8'hbc
`define SLT_CH_R    8'h1c
`define SLT_CH_A    8'h7c
`define SLT_CH_Q    8'h9c

`endif

//--- rtl/slt_pkg.sv
// Types shared by the link transmit block
package slt_pkg;
  typedef enum logic [1:0] {ST_CGS, ST_WAIT, ST_ILA, ST_DATA} slt_state_t;
endpackage

//--- rtl/slt_scrambler.sv
// Self-synchronous 1 + x^14 + x^15 octet scrambler for one lane
`timescale 1ns/10ps
`include "slt_defs.svh"
module slt_scrambler
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Octet in and out
  input  wire logic       i_adv,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_data
);
  logic [14:0] s_q;
  logic [14:0] s_d;

  // Bit 7 goes first; s_d[0] holds the newest scrambled bit
  always_comb
  begin
    s_d    = s_q;
    o_data = 8'h00;
    for (int b = 7; b >= 0; b--)
    begin
      o_data[b] = i_data[b] ^ s_d[13] ^ s_d[14];
      s_d       = {s_d[13:0], o_data[b]};
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      s_q <= `SLT_SCR_SEED;
    else if (i_adv)
      s_q <= s_d;
  end
endmodule

//--- rtl/slt_link_tx.sv
// Link transmit test patterns, alignment sequencing, scrambling and lane multiplexer
`timescale 1ns/10ps
`include "slt_defs.svh"
module slt_link_tx
  import slt_pkg::*;
#(
  parameter int LANES = 4
)
(
  // Clock and reset
  input  wire logic                 I_CLK,
  input  wire logic                 I_RST,
  // Register port
  input  wire logic                 I_REG_WR,
  input  wire logic                 I_REG_RD,
  input  wire logic [`SLT_ADDR_W-1:0] I_REG_ADDR,
  input  wire logic [7:0]           I_REG_WDATA,
  output logic      [7:0]           O_REG_RDATA,
  // Sample streams and link control
  input  wire logic [31:0]          I_SAMPLE_DATA,
  input  wire logic                 I_PACK12_MODE,
  input  wire logic                 I_SYNC_N,
  // Lane octets
  output logic      [31:0]          O_LANE_DATA,
  output logic      [3:0]           O_LANE_K,
  // Configuration outputs
  output logic      [1:0]           O_FRAME_ASSEMBLY,
  output logic                      O_MC_MASK_CLEAR,
  output logic                      O_RATIO_80X
);
  // Refuse lane counts that the fixed four-way multiplexer cannot serve
  if (LANES != 4)
  begin : g_bad_lanes
    $error("slt_link_tx serves exactly four lanes");
  end

  logic [2:0] link_test_pattern_select_q;
  logic       rpat_disparity_flip_q;
  logic       multiframe_clock_mask_clear_q;
  logic       frame_assembly_select_hi_q;
  logic       frame_assembly_select_lo_q;
  logic       ramp_pattern_enable_q;
  logic [1:0] alignment_delay_multiframes_q;
  logic       scr_en_q;
  logic [4:0] k_field_q;
  logic       k_override_q;
  logic       serial_ratio_eighty_enable_q;
  logic [7:0] lane_src_q;

  logic [5:0]  lmfc_q;
  logic [5:0]  k_frames;
  logic        mf_last;
  slt_state_t  st_q;
  logic [1:0]  dly_q;
  logic [1:0]  ila_mf_q;
  logic [3:0]  rpat_q;
  logic [7:0]  ramp_q;
  logic        ramp_active;
  logic [7:0]  ila_oct;
  logic        ila_k;
  logic [31:0] lane_d;
  logic [3:0]  lane_k_d;

  // Register writes
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      {link_test_pattern_select_q, rpat_disparity_flip_q, multiframe_clock_mask_clear_q,
       frame_assembly_select_hi_q, frame_assembly_select_lo_q, ramp_pattern_enable_q} <= `SLT_TEST_RESET;
      alignment_delay_multiframes_q <= 2'h0;
      scr_en_q                      <= 1'b0;
      k_field_q                     <= 5'h00;
      k_override_q                  <= 1'b0;
      serial_ratio_eighty_enable_q  <= 1'b0;
      lane_src_q                    <= `SLT_LANE_RESET;
    end
    else if (I_REG_WR)
    begin
      case (I_REG_ADDR)
        `SLT_ADDR_TEST_FRAME:
        begin
          link_test_pattern_select_q    <= I_REG_WDATA[`SLT_TP_MSB:`SLT_TP_LSB];
          rpat_disparity_flip_q         <= I_REG_WDATA[`SLT_RPAT_FLIP];
          multiframe_clock_mask_clear_q <= I_REG_WDATA[`SLT_MASK_CLEAR];
          frame_assembly_select_hi_q    <= I_REG_WDATA[`SLT_FA_HI];
          frame_assembly_select_lo_q    <= I_REG_WDATA[`SLT_FA_LO];
          ramp_pattern_enable_q         <= I_REG_WDATA[`SLT_RAMP_EN];
        end
        `SLT_ADDR_LINK_CTRL: k_override_q                  <= I_REG_WDATA[`SLT_OVERRIDE_BIT];
        `SLT_ADDR_ALIGN_DLY: alignment_delay_multiframes_q <= I_REG_WDATA[1:0];
        `SLT_ADDR_SCRAMBLE:  scr_en_q                      <= I_REG_WDATA[`SLT_SCR_EN_BIT];
        `SLT_ADDR_MF_LEN:    k_field_q                     <= I_REG_WDATA[4:0];
        `SLT_ADDR_LANE_SRC:  lane_src_q                    <= I_REG_WDATA;
        `SLT_ADDR_RATIO:     serial_ratio_eighty_enable_q  <= I_REG_WDATA[`SLT_RATIO80_BIT];
        default:             ;
      endcase
    end
  end

  // Register reads; unmapped addresses and reserved bits read zero
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      O_REG_RDATA <= 8'h00;
    else if (I_REG_RD)
    begin
      case (I_REG_ADDR)
        `SLT_ADDR_TEST_FRAME: O_REG_RDATA <= {link_test_pattern_select_q, rpat_disparity_flip_q,
                                              multiframe_clock_mask_clear_q, frame_assembly_select_hi_q,
                                              frame_assembly_select_lo_q, ramp_pattern_enable_q};
        `SLT_ADDR_LINK_CTRL:  O_REG_RDATA <= {k_override_q, 7'h00};
        `SLT_ADDR_ALIGN_DLY:  O_REG_RDATA <= {6'h00, alignment_delay_multiframes_q};
        `SLT_ADDR_SCRAMBLE:   O_REG_RDATA <= {scr_en_q, 7'h00};
        `SLT_ADDR_MF_LEN:     O_REG_RDATA <= {3'h0, k_field_q};
        `SLT_ADDR_LANE_SRC:   O_REG_RDATA <= lane_src_q;
        `SLT_ADDR_RATIO:      O_REG_RDATA <= {serial_ratio_eighty_enable_q, 7'h00};
        default:              O_REG_RDATA <= 8'h00;
      endcase
    end
  end

  // Multiframe counter, one frame per clock
  assign k_frames = k_override_q ? {1'b0, k_field_q} + 6'h01 : `SLT_K_DEFAULT;
  assign mf_last  = (lmfc_q >= k_frames - 6'h01);

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      lmfc_q <= 6'h00;
    else
      lmfc_q <= mf_last ? 6'h00 : lmfc_q + 6'h01;
  end

  // Link sequencing: code group sync, optional delay, alignment, data
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      st_q     <= ST_CGS;
      dly_q    <= 2'h0;
      ila_mf_q <= 2'h0;
    end
    else if (!I_SYNC_N)
    begin
      st_q     <= ST_CGS;
      ila_mf_q <= 2'h0;
    end
    else
    begin
      case (st_q)
        ST_CGS:
          if (mf_last)
          begin
            dly_q    <= alignment_delay_multiframes_q;
            ila_mf_q <= 2'h0;
            st_q     <= (alignment_delay_multiframes_q == 2'h0) ? ST_ILA : ST_WAIT;
          end
        ST_WAIT:
          if (mf_last)
          begin
            dly_q <= dly_q - 2'h1;
            if (dly_q == 2'h1)
              st_q <= ST_ILA;
          end
        ST_ILA:
          if (mf_last)
          begin
            ila_mf_q <= ila_mf_q + 2'h1;
            if (ila_mf_q == `SLT_ILA_MF_LAST && link_test_pattern_select_q != `SLT_TP_ILA)
              st_q <= ST_DATA;
          end
        ST_DATA: ;
        default: st_q <= ST_CGS;
      endcase
    end
  end

  // RPAT index and ramp source
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      rpat_q <= 4'h0;
      ramp_q <= 8'h00;
    end
    else
    begin
      rpat_q <= (rpat_q == `SLT_RPAT_LAST) ? 4'h0 : rpat_q + 4'h1;
      ramp_q <= ramp_q + 8'h01;
    end
  end

  assign ramp_active = ramp_pattern_enable_q && I_PACK12_MODE;

  function automatic logic [7:0] rpat_octet(input logic [3:0] idx);
    case (idx)
      4'h0:    rpat_octet = 8'hbe;
      4'h1:    rpat_octet = 8'hd7;
      4'h2:    rpat_octet = 8'h23;
      4'h3:    rpat_octet = 8'h47;
      4'h4:    rpat_octet = 8'h6b;
      4'h5:    rpat_octet = 8'h8f;
      4'h6:    rpat_octet = 8'hb3;
      4'h7:    rpat_octet = 8'h14;
      4'h8:    rpat_octet = 8'h5e;
      4'h9:    rpat_octet = 8'hfb;
      4'ha:    rpat_octet = 8'h35;
      default: rpat_octet = 8'h59;
    endcase
  endfunction

  // Alignment sequence octet: R opens each multiframe, A closes it, Q marks the second
  always_comb
  begin
    ila_oct = {2'h0, lmfc_q};
    ila_k   = 1'b1;
    if (lmfc_q == 6'h00)
      ila_oct = `SLT_CH_R;
    else if (mf_last)
      ila_oct = `SLT_CH_A;
    else if (ila_mf_q == 2'h1 && lmfc_q == 6'h01)
      ila_oct = `SLT_CH_Q;
    else
      ila_k = 1'b0;
  end

  for (genvar g = 0; g < 4; g++)
  begin : g_lane
    logic [1:0] src;
    logic [7:0] payload;
    logic [7:0] scr_out;
    logic [7:0] oct;
    logic       kk;

    assign src     = 2'(g) + lane_src_q[7-2*g -: 2];
    assign payload = ramp_active ? ramp_q : I_SAMPLE_DATA[8*src +: 8];

    slt_scrambler u_scr
    (
      .i_clk  (I_CLK),
      .i_rst  (I_RST),
      .i_adv  (scr_en_q && st_q == ST_DATA),
      .i_data (payload),
      .o_data (scr_out)
    );

    always_comb
    begin
      oct = 8'h00;
      kk  = 1'b0;
      case (link_test_pattern_select_q)
        `SLT_TP_D215: oct = `SLT_CH_D215;
        `SLT_TP_K285:
        begin
          oct = `SLT_CH_K285;
          kk  = 1'b1;
        end
        `SLT_TP_RPAT: oct = rpat_octet(rpat_q) ^ ((rpat_disparity_flip_q && rpat_q == 4'h0) ? 8'hff : 8'h00);
        default:
          case (st_q)
            ST_ILA:
            begin
              oct = ila_oct;
              kk  = ila_k;
            end
            ST_DATA: oct = scr_en_q ? scr_out : payload;
            default:
            begin
              oct = `SLT_CH_K285;
              kk  = 1'b1;
            end
          endcase
      endcase
    end

    assign lane_d[8*g +: 8] = oct;
    assign lane_k_d[g]      = kk;
  end

  // Registered lane and configuration outputs
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      O_LANE_DATA      <= 32'h0;
      O_LANE_K         <= 4'h0;
      O_FRAME_ASSEMBLY <= 2'h0;
      O_MC_MASK_CLEAR  <= 1'b0;
      O_RATIO_80X      <= 1'b0;
    end
    else
    begin
      O_LANE_DATA      <= lane_d;
      O_LANE_K         <= lane_k_d;
      O_FRAME_ASSEMBLY <= {frame_assembly_select_hi_q, frame_assembly_select_lo_q};
      O_MC_MASK_CLEAR  <= multiframe_clock_mask_clear_q;
      O_RATIO_80X      <= serial_ratio_eighty_enable_q;
    end
  end

  a_normal_data: assert property (@(posedge I_CLK) disable iff (I_RST)
    ((link_test_pattern_select_q == 3'h0 || link_test_pattern_select_q > `SLT_TP_RPAT) && st_q == ST_DATA
     && !scr_en_q && !ramp_active && lane_src_q == 8'h00) |=> O_LANE_DATA == $past(I_SAMPLE_DATA))
    else $error("normal data not passed through");

  a_d215_pattern: assert property (@(posedge I_CLK) disable iff (I_RST)
    (link_test_pattern_select_q == `SLT_TP_D215) |=> (O_LANE_DATA == {4{8'hb5}} && O_LANE_K == 4'h0))
    else $error("D21.5 pattern wrong");

  a_k285_pattern: assert property (@(posedge I_CLK) disable iff (I_RST)
    (link_test_pattern_select_q == `SLT_TP_K285) |=> (O_LANE_DATA == {4{8'hbc}} && O_LANE_K == 4'hf))
    else $error("K28.5 pattern wrong");

  a_ila_repeat: assert property (@(posedge I_CLK) disable iff (I_RST)
    (link_test_pattern_select_q == `SLT_TP_ILA && st_q == ST_ILA && I_SYNC_N) |=> st_q == ST_ILA)
    else $error("alignment repeat left the sequence");

  a_rpat_start: assert property (@(posedge I_CLK) disable iff (I_RST)
    (link_test_pattern_select_q == `SLT_TP_RPAT && !rpat_disparity_flip_q && rpat_q == 4'h0)
    |=> O_LANE_DATA[7:0] == 8'hbe ##11 rpat_q == 4'h0)
    else $error("RPAT sequence wrong");

  a_rpat_flip: assert property (@(posedge I_CLK) disable iff (I_RST)
    (link_test_pattern_select_q == `SLT_TP_RPAT && rpat_disparity_flip_q && rpat_q == 4'h0)
    |=> O_LANE_DATA[7:0] == 8'h41)
    else $error("RPAT disparity change missing");

  a_reset_fields: assert property (@(posedge I_CLK)
    $fell(I_RST) |-> (frame_assembly_select_hi_q && !frame_assembly_select_lo_q && !scr_en_q))
    else $error("reset values wrong");

  a_ila_delay: assert property (@(posedge I_CLK) disable iff (I_RST)
    (st_q == ST_CGS && I_SYNC_N && mf_last)
    |=> (st_q == (($past(alignment_delay_multiframes_q) == 2'h0) ? ST_ILA : ST_WAIT)))
    else $error("alignment delay entry wrong");

  a_default_k: assert property (@(posedge I_CLK) disable iff (I_RST)
    (lmfc_q == 6'h00 && !k_override_q && !I_REG_WR) ##1 (!I_REG_WR)[*4] |-> mf_last)
    else $error("default multiframe is not five frames");

  a_lane_swap: assert property (@(posedge I_CLK) disable iff (I_RST)
    (link_test_pattern_select_q == 3'h0 && st_q == ST_DATA && !scr_en_q && !ramp_active && lane_src_q == 8'h55)
    |=> (O_LANE_DATA[7:0] == $past(I_SAMPLE_DATA[15:8]) && O_LANE_DATA[31:24] == $past(I_SAMPLE_DATA[7:0])))
    else $error("lane multiplexer wrong");
endmodule

//--- sim/slt_rx_model.sv
// Receiver model: holds sync low until it has seen code group sync on every lane
`timescale 1ns/10ps
`include "slt_defs.svh"
module slt_rx_model
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Link request from the bench
  input  wire logic        i_link_up,
  // Lane octets from the transmitter
  input  wire logic [31:0] i_lane_data,
  input  wire logic [3:0]  i_lane_k,
  // Receiver sync, active low
  output logic             o_sync_n
);
  logic [2:0] k_run_q;
  logic       sync_n_q;

  // Four K28.5 in a row on all lanes count as code group sync
  always_ff @(posedge i_clk)
  begin
    if (i_rst || !i_link_up)
      k_run_q <= 3'h0;
    else if (i_lane_k === 4'hf && i_lane_data === {4{`SLT_CH_K285}})
    begin
      if (k_run_q != 3'h4)
        k_run_q <= k_run_q + 3'h1;
    end
    else if (!sync_n_q)
      k_run_q <= 3'h0;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      sync_n_q <= 1'b0;
    else
      sync_n_q <= i_link_up && (k_run_q == 3'h4);
  end

  assign o_sync_n = sync_n_q;
endmodule

//--- sim/tb.sv
// Testbench of the link transmit block
`timescale 1ns/10ps
`include "slt_defs.svh"
module tb;
  logic        clk     = 1'b0;
  logic        rst     = 1'b1;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [7:0]  addr    = 8'h00;
  logic [7:0]  wdata   = 8'h00;
  logic [31:0] samp    = 32'h44332211;
  logic        pack12  = 1'b0;
  logic        link_up = 1'b0;
  logic [7:0]  rdata;
  logic        sync_n;
  logic [31:0] lane;
  logic [3:0]  lk;
  logic [1:0]  fa;
  logic        mcc;
  logic        r80;
  logic [7:0]  a;
  logic        hit;
  int          n_errors    = 0;
  int          comparisons = 0;
  int          cyc         = 0;
  int          n;
  logic [2:0]  tps [0:5] = '{3'h0, 3'h5, 3'h6, 3'h7, 3'h1, 3'h2};
  logic [31:0] tpd [0:5] = '{32'h44332211, 32'h44332211, 32'h44332211, 32'h44332211, 32'hb5b5b5b5, 32'hbcbcbcbc};
  logic [3:0]  tpk [0:5] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'hf};
  logic [7:0]  mxv [0:4] = '{8'h00, 8'h55, 8'haa, 8'hff, 8'h1b};

  always #20 clk = ~clk;

  slt_link_tx DUT (.I_CLK(clk), .I_RST(rst), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr),
    .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .I_SAMPLE_DATA(samp), .I_PACK12_MODE(pack12),
    .I_SYNC_N(sync_n), .O_LANE_DATA(lane), .O_LANE_K(lk), .O_FRAME_ASSEMBLY(fa),
    .O_MC_MASK_CLEAR(mcc), .O_RATIO_80X(r80));

  slt_rx_model rx (.i_clk(clk), .i_rst(rst), .i_link_up(link_up), .i_lane_data(lane), .i_lane_k(lk),
    .o_sync_n(sync_n));

  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wreg(input logic [7:0] ad, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = ad;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
    @(negedge clk);
    rd = 1'b1;
    addr = ad;
    @(negedge clk);
    rd = 1'b0;
    chk("read data", {24'h0, e}, {24'h0, rdata});
  endtask

  // Counts cycles until lane 0 carries the multiframe start character
  task automatic wait_r(output int c);
    c = 0;
    do
    begin
      @(negedge clk);
      c++;
    end
    while (!(lk[0] === 1'b1 && lane[7:0] === `SLT_CH_R) && c < 60);
  endtask

  task automatic link_start(output int c);
    @(negedge clk);
    link_up = 1'b0;
    repeat (3) @(negedge clk);
    link_up = 1'b1;
    c = 0;
    while (sync_n !== 1'b1 && c < 50)
    begin
      @(negedge clk);
      c++;
    end
    wait_r(c);
  endtask

  task automatic rpat_chk(input logic [7:0] want, input logic [7:0] bad);
    logic [7:0] h [0:23];
    logic       ok;
    repeat (2) @(negedge clk);
    for (int j = 0; j < 24; j++)
    begin
      h[j] = lane[7:0];
      @(negedge clk);
    end
    ok = 1'b1;
    hit = 1'b0;
    for (int j = 0; j < 12; j++)
    begin
      ok &= (h[j] === h[j + 12]) && (h[j] !== bad);
      hit |= (h[j] === want);
    end
    chk("rpat period and octet", 32'h3, {30'h0, ok, hit});
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("frame assembly", 32'h2, {30'h0, fa});
    rchk(`SLT_ADDR_TEST_FRAME, 8'h04);
    rchk(`SLT_ADDR_SCRAMBLE, 8'h00);
    rchk(`SLT_ADDR_LANE_SRC, 8'h00);
    wreg(`SLT_ADDR_ALIGN_DLY, 8'hff);
    rchk(`SLT_ADDR_ALIGN_DLY, 8'h03);
    wreg(`SLT_ADDR_MF_LEN, 8'hff);
    rchk(`SLT_ADDR_MF_LEN, 8'h1f);
    wreg(`SLT_ADDR_SCRAMBLE, 8'hff);
    rchk(`SLT_ADDR_SCRAMBLE, 8'h80);
    wreg(8'h55, 8'hff);
    rchk(8'h55, 8'h00);
    wreg(`SLT_ADDR_TEST_FRAME, 8'h08);
    @(negedge clk);
    chk("mask clear and assembly", 32'h4, {29'h0, mcc, fa});
    wreg(`SLT_ADDR_LANE_SRC, 8'h70);
    wreg(`SLT_ADDR_RATIO, 8'h80);
    @(negedge clk);
    chk("ratio 80x", 32'h1, {31'h0, r80});
    wreg(`SLT_ADDR_RATIO, 8'h00);
    @(negedge clk);
    chk("ratio 80x off", 32'h0, {31'h0, r80});
    wreg(`SLT_ADDR_LANE_SRC, 8'h00);
    wreg(`SLT_ADDR_SCRAMBLE, 8'h00);
    wreg(`SLT_ADDR_ALIGN_DLY, 8'h00);
    link_start(n);
    chk("ila start no delay", 32'h1, {31'h0, n >= 1 && n <= 8});
    wait_r(n);
    chk("default frames", 32'd5, n);
    repeat (20) @(negedge clk);
    for (int m = 0; m < 5; m++)
    begin
      wreg(`SLT_ADDR_LANE_SRC, mxv[m]);
      repeat (2) @(negedge clk);
      for (int i = 0; i < 4; i++)
        a = samp[8 * ((i + mxv[m][7 - 2 * i -: 2]) % 4) +: 8];
      chk("lane 3 source", {24'h0, a}, {24'h0, lane[31:24]});
      chk("lane 0 source", {24'h0, samp[8 * mxv[m][7:6] +: 8]}, {24'h0, lane[7:0]});
    end
    wreg(`SLT_ADDR_LANE_SRC, 8'h00);
    for (int t = 0; t < 6; t++)
    begin
      wreg(`SLT_ADDR_TEST_FRAME, {tps[t], 5'h00});
      repeat (2) @(negedge clk);
      chk("pattern lanes", tpd[t], lane);
      chk("pattern k", {28'h0, tpk[t]}, {28'h0, lk});
    end
    wreg(`SLT_ADDR_TEST_FRAME, 8'h80);
    rpat_chk(8'hbe, 8'h41);
    wreg(`SLT_ADDR_TEST_FRAME, 8'h90);
    rpat_chk(8'h41, 8'hbe);
    wreg(`SLT_ADDR_TEST_FRAME, 8'h10);
    repeat (2) @(negedge clk);
    chk("flip outside rpat", samp, lane);
    pack12 = 1'b1;
    wreg(`SLT_ADDR_TEST_FRAME, 8'h01);
    repeat (2) @(negedge clk);
    a = lane[7:0];
    @(negedge clk);
    chk("ramp step", {24'h0, a + 8'h01}, {24'h0, lane[7:0]});
    pack12 = 1'b0;
    repeat (2) @(negedge clk);
    chk("ramp needs packing", samp, lane);
    wreg(`SLT_ADDR_TEST_FRAME, 8'h00);
    wreg(`SLT_ADDR_SCRAMBLE, 8'h80);
    hit = 1'b0;
    repeat (4)
    begin
      @(negedge clk);
      hit |= (lane !== samp);
    end
    chk("scrambled differs", 32'h1, {31'h0, hit});
    wreg(`SLT_ADDR_SCRAMBLE, 8'h00);
    repeat (2) @(negedge clk);
    chk("unscrambled", samp, lane);
    wreg(`SLT_ADDR_ALIGN_DLY, 8'h03);
    wreg(`SLT_ADDR_LINK_CTRL, 8'h80);
    wreg(`SLT_ADDR_MF_LEN, 8'h02);
    link_start(n);
    chk("ila start delayed", 32'h1, {31'h0, n >= 10 && n <= 15});
    wait_r(n);
    chk("programmed frames", 32'd3, n);
    wreg(`SLT_ADDR_TEST_FRAME, 8'h60);
    link_start(n);
    repeat (40) @(negedge clk);
    wait_r(n);
    chk("ila repeats", 32'h1, {31'h0, n >= 1 && n <= 3});
    wrap_up();
  end
endmodule
